// ==== rtl/can_mode_timing_error_regs.v ====
// Purpose: mode select, bit timing, error counters, error flags, status
// Assumes: protocol engine events are one-clock pulses on clk
// Notes: register bit n of the word is vector bit 31-n
`timescale 1ns/100ps
`include "can_mtr_consts.vh"

module can_mode_timing_error_regs #(
    parameter PRESC_W = 8
) (
    input wire clk, // system clock, 20 MHz
    input wire sys_rst, // synchronous reset, high
    input wire [7:0] reg_addr, // register byte address
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    input wire [31:0] reg_wdata, // write data
    output reg [31:0] reg_rdata, // read data, one clock later
    output reg reg_rvalid, // read data valid pulse
    input wire pe_ack_err, // engine: ack error
    input wire pe_bit_err, // engine: bit error
    input wire pe_stuff_err, // engine: stuff error
    input wire pe_form_err, // engine: form error
    input wire pe_crc_err, // engine: crc mismatch
    input wire pe_crc_delim_err, // engine: crc delimiter corrupted
    input wire pe_rx_inc1, // engine: receive count +1
    input wire pe_rx_inc8, // engine: receive count +8
    input wire pe_tx_inc8, // engine: transmit count +8
    input wire pe_rx_dec, // engine: receive count -1
    input wire pe_tx_dec, // engine: transmit count -1
    input wire pe_recessive_run, // engine: 11 recessive bits seen
    input wire pe_wakeup, // engine: bus activity in sleep
    input wire filter_busy_in, // filter busy level
    input wire tx_queue_full_in, // transmit queue full level
    input wire priority_buffer_full_in, // priority buffer full level
    input wire line_busy_in, // frame on the bus
    output reg core_on_bit, // core enabled
    output reg mode_config, // configuration mode
    output reg mode_normal, // normal mode
    output reg mode_sleep, // sleep mode
    output reg mode_loopback, // loopback mode
    output reg drive_recessive, // force recessive on bus
    output reg bus_off, // bus-off state
    output reg [1:0] fault_state_code, // error state code
    output reg [4:0] seg1_quanta, // segment one length in quanta
    output reg [3:0] seg2_quanta, // segment two length in quanta
    output reg [2:0] sjw_quanta, // jump width in quanta
    output wire tq_tick // quantum pulse, from divider flop
);

// ************************************************
// declarations
// ************************************************

reg core_on_ff;
reg sleep_sel_ff;
reg loopback_sel_ff;
reg [PRESC_W-1:0] quantum_divider_ff;
reg [3:0] segment_one_len_ff;
reg [2:0] segment_two_len_ff;
reg [1:0] resync_jump_len_ff;
reg [7:0] rx_fault_count_ff;
reg [7:0] tx_fault_count_ff;
reg [`FLAG_BITS-1:0] fault_flags_ff;
reg config_ff;
reg bus_off_ff;

reg nxt_core_on;
reg nxt_sleep_sel;
reg nxt_loopback_sel;
reg [PRESC_W-1:0] nxt_quantum_divider;
reg [3:0] nxt_segment_one_len;
reg [2:0] nxt_segment_two_len;
reg [1:0] nxt_resync_jump_len;
reg [7:0] nxt_rx_count;
reg [7:0] nxt_tx_count;
reg [`FLAG_BITS-1:0] nxt_flags;
reg [`FLAG_BITS-1:0] flag_set;
reg nxt_config;
reg nxt_bus_off;
reg [8:0] rx_sum;
reg [8:0] tx_sum;
reg [31:0] nxt_rdata;
reg [1:0] nxt_state_code;

wire wr_reset_ctl;
wire soft_reset;
wire core_off_write;
wire cfg_writable;

// ************************************************
// helper functions
// ************************************************

// count update: add amount, take one away unless count is zero, result 9 bits
function [8:0] count_step;
    input [7:0] cnt;
    input [3:0] add;
    input dec;
    begin
        count_step = {1'b0, cnt} + {5'h00, add};
        if (dec && (cnt != 8'h00)) begin
            count_step = count_step - 9'h001;
        end
    end
endfunction

// clamp a 9-bit count to 8 bits
function [7:0] clamp8;
    input [8:0] val;
    begin
        if (val > `COUNT_MAX) begin
            clamp8 = 8'hFF;
        end else begin
            clamp8 = val[7:0];
        end
    end
endfunction

// ************************************************
// write decode
// ************************************************

// reset control register writes
assign wr_reset_ctl = reg_wr && (reg_addr == `OFS_RESET_CONTROL);
assign soft_reset = wr_reset_ctl && reg_wdata[`POS_SOFT_RESET];
assign core_off_write = wr_reset_ctl && !reg_wdata[`POS_CORE_ON];
assign cfg_writable = !core_on_ff;

// ************************************************
// configuration registers
// ************************************************

// mode selects, prescaler, timing fields
always @* begin
    nxt_core_on = core_on_ff;
    nxt_sleep_sel = sleep_sel_ff;
    nxt_loopback_sel = loopback_sel_ff;
    nxt_quantum_divider = quantum_divider_ff;
    nxt_segment_one_len = segment_one_len_ff;
    nxt_segment_two_len = segment_two_len_ff;
    nxt_resync_jump_len = resync_jump_len_ff;
    if (wr_reset_ctl) begin
        nxt_core_on = reg_wdata[`POS_CORE_ON];
    end
    if (reg_wr && (reg_addr == `OFS_MODE_SELECT)) begin
        nxt_sleep_sel = reg_wdata[`POS_SLEEP_SEL];
        if (cfg_writable) begin
            nxt_loopback_sel = reg_wdata[`POS_LOOPBACK_SEL];
        end
    end
    if (reg_wr && cfg_writable && (reg_addr == `OFS_PRESCALER)) begin
        nxt_quantum_divider = reg_wdata[`PRESCALER_MSB:0];
    end
    if (reg_wr && cfg_writable && (reg_addr == `OFS_TIMING)) begin
        nxt_segment_one_len = reg_wdata[`SEG1_MSB:`SEG1_LSB];
        nxt_segment_two_len = reg_wdata[`SEG2_MSB:`SEG2_LSB];
        nxt_resync_jump_len = reg_wdata[`SJW_MSB:`SJW_LSB];
    end
    // wake from sleep drops the select on its own
    if (pe_wakeup && mode_sleep) begin
        nxt_sleep_sel = 1'b0;
    end
    // soft reset returns every configuration register to zero
    if (soft_reset) begin
        nxt_core_on = 1'b0;
        nxt_sleep_sel = 1'b0;
        nxt_loopback_sel = 1'b0;
        nxt_quantum_divider = {PRESC_W{1'b0}};
        nxt_segment_one_len = 4'h0;
        nxt_segment_two_len = 3'h0;
        nxt_resync_jump_len = 2'h0;
    end
end

// configuration flops
always @(posedge clk) begin
    if (sys_rst) begin
        core_on_ff <= 1'b0;
        sleep_sel_ff <= 1'b0;
        loopback_sel_ff <= 1'b0;
        quantum_divider_ff <= {PRESC_W{1'b0}};
        segment_one_len_ff <= 4'h0;
        segment_two_len_ff <= 3'h0;
        resync_jump_len_ff <= 2'h0;
    end else begin
        core_on_ff <= nxt_core_on;
        sleep_sel_ff <= nxt_sleep_sel;
        loopback_sel_ff <= nxt_loopback_sel;
        quantum_divider_ff <= nxt_quantum_divider;
        segment_one_len_ff <= nxt_segment_one_len;
        segment_two_len_ff <= nxt_segment_two_len;
        resync_jump_len_ff <= nxt_resync_jump_len;
    end
end

// ************************************************
// mode state
// ************************************************

// config until enabled and 11 recessive bits seen
always @* begin
    nxt_config = config_ff;
    if (!nxt_core_on) begin
        nxt_config = 1'b1;
    end else if (pe_recessive_run) begin
        nxt_config = 1'b0;
    end
end

// mode outputs; loopback outranks sleep
always @(posedge clk) begin
    if (sys_rst) begin
        config_ff <= 1'b1;
        mode_config <= 1'b1;
        drive_recessive <= 1'b1;
        mode_loopback <= 1'b0;
        mode_sleep <= 1'b0;
        mode_normal <= 1'b0;
        core_on_bit <= 1'b0;
    end else begin
        config_ff <= nxt_config;
        mode_config <= nxt_config;
        drive_recessive <= nxt_config;
        mode_loopback <= !nxt_config && nxt_loopback_sel;
        mode_sleep <= !nxt_config && nxt_sleep_sel && !nxt_loopback_sel;
        mode_normal <= !nxt_config && !nxt_sleep_sel && !nxt_loopback_sel;
        core_on_bit <= nxt_core_on;
    end
end

// ************************************************
// error counters and bus-off
// ************************************************

// counter arithmetic, bus-off entry and recovery
always @* begin
    rx_sum = count_step(rx_fault_count_ff, {pe_rx_inc8, 2'b00, pe_rx_inc1}, pe_rx_dec);
    tx_sum = count_step(tx_fault_count_ff, {pe_tx_inc8, 3'b000}, pe_tx_dec);
    nxt_rx_count = clamp8(rx_sum);
    nxt_tx_count = tx_sum[7:0];
    nxt_bus_off = bus_off_ff;
    if (config_ff) begin
        nxt_rx_count = rx_fault_count_ff;
        nxt_tx_count = tx_fault_count_ff;
    end else if (bus_off_ff) begin
        nxt_rx_count = rx_fault_count_ff;
        nxt_tx_count = tx_fault_count_ff;
        if (pe_recessive_run) begin
            if (rx_fault_count_ff == `RECOVERY_LAST) begin
                nxt_bus_off = 1'b0;
                nxt_rx_count = 8'h00;
                nxt_tx_count = 8'h00;
            end else begin
                nxt_rx_count = rx_fault_count_ff + 8'h01;
            end
        end
    end else if (tx_sum >= `BUS_OFF_LEVEL) begin
        nxt_bus_off = 1'b1;
        nxt_rx_count = 8'h00;
        nxt_tx_count = 8'h00;
    end
    if (soft_reset || core_off_write) begin
        nxt_rx_count = 8'h00;
        nxt_tx_count = 8'h00;
        nxt_bus_off = 1'b0;
    end
end

// counter flops
always @(posedge clk) begin
    if (sys_rst) begin
        rx_fault_count_ff <= 8'h00;
        tx_fault_count_ff <= 8'h00;
        bus_off_ff <= 1'b0;
        bus_off <= 1'b0;
    end else begin
        rx_fault_count_ff <= nxt_rx_count;
        tx_fault_count_ff <= nxt_tx_count;
        bus_off_ff <= nxt_bus_off;
        bus_off <= nxt_bus_off;
    end
end

// fault state code from mode and counts
always @* begin
    if (nxt_config) begin
        nxt_state_code = `FSC_CONFIG;
    end else if (nxt_bus_off) begin
        nxt_state_code = `FSC_BUS_OFF;
    end else if (({1'b0, nxt_tx_count} >= `PASSIVE_LEVEL) || ({1'b0, nxt_rx_count} >= `PASSIVE_LEVEL)) begin
        nxt_state_code = `FSC_PASSIVE;
    end else begin
        nxt_state_code = `FSC_ACTIVE;
    end
end

// state code flop
always @(posedge clk) begin
    if (sys_rst) begin
        fault_state_code <= `FSC_CONFIG;
    end else begin
        fault_state_code <= nxt_state_code;
    end
end

// ************************************************
// error flags
// ************************************************

// sticky flags; set wins over any clear
always @* begin
    flag_set = {`FLAG_BITS{1'b0}};
    flag_set[`POS_ACK_FLAG] = pe_ack_err;
    flag_set[`POS_BIT_FLAG] = pe_bit_err;
    flag_set[`POS_STUFF_FLAG] = pe_stuff_err;
    flag_set[`POS_FORM_FLAG] = pe_form_err || (pe_crc_err && pe_crc_delim_err);
    flag_set[`POS_CRC_FLAG] = pe_crc_err && !pe_crc_delim_err;
    nxt_flags = fault_flags_ff;
    if (reg_wr && (reg_addr == `OFS_FLAGS)) begin
        nxt_flags = nxt_flags & ~reg_wdata[`FLAG_BITS-1:0];
    end
    if (soft_reset || core_off_write) begin
        nxt_flags = {`FLAG_BITS{1'b0}};
    end
    nxt_flags = nxt_flags | flag_set;
end

// flag flops
always @(posedge clk) begin
    if (sys_rst) begin
        fault_flags_ff <= {`FLAG_BITS{1'b0}};
    end else begin
        fault_flags_ff <= nxt_flags;
    end
end

// ************************************************
// timing outputs and quantum divider
// ************************************************

// effective lengths are field plus one
always @(posedge clk) begin
    if (sys_rst) begin
        seg1_quanta <= 5'h01;
        seg2_quanta <= 4'h1;
        sjw_quanta <= 3'h1;
    end else begin
        seg1_quanta <= {1'b0, segment_one_len_ff} + 5'h01;
        seg2_quanta <= {1'b0, segment_two_len_ff} + 4'h1;
        sjw_quanta <= {1'b0, resync_jump_len_ff} + 3'h1;
    end
end

// quantum tick, stopped in configuration
tq_divider #(
    .WIDTH(PRESC_W)
) u_tq_divider (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(!config_ff),
    .divisor(quantum_divider_ff),
    .tq_tick(tq_tick)
);

// ************************************************
// read port
// ************************************************

// read mux; unmapped and reserved bits read zero
always @* begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr)
        `OFS_RESET_CONTROL: begin
            nxt_rdata[`POS_CORE_ON] = core_on_ff;
        end
        `OFS_MODE_SELECT: begin
            nxt_rdata[`POS_SLEEP_SEL] = sleep_sel_ff;
            nxt_rdata[`POS_LOOPBACK_SEL] = loopback_sel_ff;
        end
        `OFS_PRESCALER: begin
            nxt_rdata[`PRESCALER_MSB:0] = quantum_divider_ff;
        end
        `OFS_TIMING: begin
            nxt_rdata[`SEG1_MSB:`SEG1_LSB] = segment_one_len_ff;
            nxt_rdata[`SEG2_MSB:`SEG2_LSB] = segment_two_len_ff;
            nxt_rdata[`SJW_MSB:`SJW_LSB] = resync_jump_len_ff;
        end
        `OFS_COUNTERS: begin
            nxt_rdata[`TXCNT_MSB:`TXCNT_LSB] = tx_fault_count_ff;
            nxt_rdata[`RXCNT_MSB:`RXCNT_LSB] = rx_fault_count_ff;
        end
        `OFS_FLAGS: begin
            nxt_rdata[`FLAG_BITS-1:0] = fault_flags_ff;
        end
        `OFS_STATUS: begin
            nxt_rdata[`POS_ST_CONFIG] = mode_config;
            nxt_rdata[`POS_ST_LOOPBACK] = mode_loopback;
            nxt_rdata[`POS_ST_SLEEP] = mode_sleep;
            nxt_rdata[`POS_ST_NORMAL] = mode_normal;
            nxt_rdata[`POS_ST_IDLE] = !mode_config && !line_busy_in;
            nxt_rdata[`POS_ST_BUSY] = !mode_config && line_busy_in;
            nxt_rdata[`POS_ST_WARN] = ({1'b0, tx_fault_count_ff} >= `WARN_LEVEL) ||
                ({1'b0, rx_fault_count_ff} >= `WARN_LEVEL);
            nxt_rdata[`ST_STATE_MSB:`ST_STATE_LSB] = fault_state_code;
            nxt_rdata[`POS_ST_PRIO_FULL] = priority_buffer_full_in;
            nxt_rdata[`POS_ST_TXQ_FULL] = tx_queue_full_in;
            nxt_rdata[`POS_ST_FILTER_BUSY] = filter_busy_in;
        end
        default: begin
            nxt_rdata = 32'h0000_0000;
        end
    endcase
end

// read data register, valid one clock after strobe
always @(posedge clk) begin
    if (sys_rst) begin
        reg_rdata <= 32'h0000_0000;
        reg_rvalid <= 1'b0;
    end else begin
        reg_rvalid <= reg_rd;
        if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end
    end
end

endmodule // can_mode_timing_error_regs

// ==== rtl/can_mtr_consts.vh ====
// Purpose: constants for the mode, timing and error register block
// Assumes: register bit n (big-endian numbering) sits at vector bit 31-n
// Notes: offsets are byte addresses on the host register port
`ifndef CAN_MTR_CONSTS_VH
`define CAN_MTR_CONSTS_VH

// register byte offsets
`define OFS_RESET_CONTROL 8'h00
`define OFS_MODE_SELECT 8'h04
`define OFS_PRESCALER 8'h08
`define OFS_TIMING 8'h0C
`define OFS_COUNTERS 8'h10
`define OFS_FLAGS 8'h14
`define OFS_STATUS 8'h18

// reset control fields (vector positions)
`define POS_SOFT_RESET 0
`define POS_CORE_ON 1

// mode select fields
`define POS_SLEEP_SEL 0
`define POS_LOOPBACK_SEL 1

// prescaler and timing fields
`define PRESCALER_MSB 7
`define SEG1_LSB 0
`define SEG1_MSB 3
`define SEG2_LSB 4
`define SEG2_MSB 6
`define SJW_LSB 7
`define SJW_MSB 8

// counter register fields
`define TXCNT_LSB 0
`define TXCNT_MSB 7
`define RXCNT_LSB 8
`define RXCNT_MSB 15

// error flag positions
`define POS_CRC_FLAG 0
`define POS_FORM_FLAG 1
`define POS_STUFF_FLAG 2
`define POS_BIT_FLAG 3
`define POS_ACK_FLAG 4
`define FLAG_BITS 5

// status positions
`define POS_ST_CONFIG 0
`define POS_ST_LOOPBACK 1
`define POS_ST_SLEEP 2
`define POS_ST_NORMAL 3
`define POS_ST_IDLE 4
`define POS_ST_BUSY 5
`define POS_ST_WARN 6
`define ST_STATE_LSB 7
`define ST_STATE_MSB 8
`define POS_ST_PRIO_FULL 9
`define POS_ST_TXQ_FULL 10
`define POS_ST_FILTER_BUSY 11

// fault state codes
`define FSC_CONFIG 2'h0
`define FSC_ACTIVE 2'h1
`define FSC_PASSIVE 2'h3
`define FSC_BUS_OFF 2'h2

// counter thresholds
`define WARN_LEVEL 9'h060
`define PASSIVE_LEVEL 9'h080
`define BUS_OFF_LEVEL 9'h100
`define COUNT_MAX 9'h0FF
`define RECOVERY_LAST 8'h7F

`endif

// ==== rtl/tq_divider.v ====
// Purpose: time quantum tick generator
// Assumes: divisor is the programmed prescaler value
// Notes: tick period is divisor plus one clocks
`timescale 1ns/100ps

module tq_divider #(
    parameter WIDTH = 8
) (
    input wire clk, // system clock
    input wire sys_rst, // synchronous reset, high
    input wire run, // counting allowed
    input wire [WIDTH-1:0] divisor, // programmed prescaler
    output reg tq_tick // one-clock quantum pulse
);

reg [WIDTH-1:0] cnt_ff;
reg [WIDTH-1:0] nxt_cnt;
reg nxt_tick;

// ************************************************
// divide count
// ************************************************

// wrap at divisor, so period is divisor + 1
always @* begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!run) begin
        nxt_cnt = {WIDTH{1'b0}};
    end else if (cnt_ff == divisor) begin
        nxt_cnt = {WIDTH{1'b0}};
        nxt_tick = 1'b1;
    end else begin
        nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end

// count and tick registers
always @(posedge clk) begin
    if (sys_rst) begin
        cnt_ff <= {WIDTH{1'b0}};
        tq_tick <= 1'b0;
    end else begin
        cnt_ff <= nxt_cnt;
        tq_tick <= nxt_tick;
    end
end

endmodule // tq_divider

// ==== verif/can_mtr_checker_properties.sv ====
// Purpose: port-level checks on the mode, timing and error register block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance of the block below
`timescale 1ns/100ps

module can_mtr_checker (
    input logic clk, // system clock
    input logic sys_rst, // synchronous reset
    input logic reg_rd, // read strobe
    input logic reg_rvalid, // read answer
    input logic pe_wakeup, // bus activity
    input logic core_on_bit, // core enabled
    input logic mode_config, // configuration mode
    input logic mode_normal, // normal mode
    input logic mode_sleep, // sleep mode
    input logic mode_loopback, // loopback mode
    input logic drive_recessive, // bus forced recessive
    input logic bus_off, // bus-off state
    input logic [1:0] fault_state_code, // error state code
    input logic [4:0] seg1_quanta, // segment one quanta
    input logic [3:0] seg2_quanta, // segment two quanta
    input logic [2:0] sjw_quanta, // jump width quanta
    input logic tq_tick // quantum pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ************************************
    // mode and state relations
    // ************************************
    chk_one_mode: assert property ($onehot({mode_config, mode_normal, mode_sleep, mode_loopback}))
        else $error("mode flags not one-hot");
    chk_recessive_config: assert property (drive_recessive == mode_config)
        else $error("recessive drive differs from config mode");
    chk_off_config: assert property (!core_on_bit |-> mode_config)
        else $error("core off but not in config mode");
    chk_config_code: assert property (mode_config |-> fault_state_code == 2'h0)
        else $error("config mode with nonzero state code");
    chk_busoff_code: assert property (bus_off |-> fault_state_code == 2'h2)
        else $error("bus-off with wrong state code");
    chk_wake_clears: assert property (mode_sleep && pe_wakeup |-> ##[1:2] !mode_sleep)
        else $error("sleep kept after wake");
    chk_quiet_config: assert property (mode_config [*3] |-> !tq_tick)
        else $error("quantum tick in config mode");
    chk_quanta_range: assert property (seg1_quanta inside {[5'h01:5'h10]} && seg2_quanta inside {[4'h1:4'h8]}
        && sjw_quanta inside {[3'h1:3'h4]})
        else $error("segment length out of range");

    // read port answers one cycle after each strobe, never otherwise
    chk_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_no_stray: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
endmodule // can_mtr_checker

bind can_mode_timing_error_regs can_mtr_checker u_chk (.clk, .sys_rst, .reg_rd, .reg_rvalid, .pe_wakeup,
    .core_on_bit, .mode_config, .mode_normal, .mode_sleep, .mode_loopback, .drive_recessive, .bus_off,
    .fault_state_code, .seg1_quanta, .seg2_quanta, .sjw_quanta, .tq_tick);

// ==== verif/can_engine_model.sv ====
// Purpose: stand-in for the protocol engine event side
// Assumes: requests last one cycle
// Notes: bit5 qualifies bit4, bit11 marks a run of 11 recessive bits
`timescale 1ns/100ps

module can_engine_model (
    input logic clk, // system clock
    input logic sys_rst, // synchronous reset
    input logic [12:0] ev_req, // events asked by the bench
    output logic [12:0] ev // one-clock engine pulses
);
    // each request bit is registered and passed on one clock later, unchanged
    always @(posedge clk) begin
        if (sys_rst) begin
            ev <= 13'h0000;
        end else begin
            ev <= ev_req;
        end
    end
endmodule // can_engine_model

// ==== verif/can_mode_timing_error_regs_tb_top.sv ====
// Purpose: self-checking bench for the register block
// Assumes: strobe register port, documented bit n at vector bit 31-n
// Notes: reads queue expectations, a monitor compares answers
`timescale 1ns/100ps

module can_mode_timing_error_regs_tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata, seed, p, t, lv;
    logic reg_rvalid, core_on_bit, mode_config, mode_normal, mode_sleep, mode_loopback;
    logic drive_recessive, bus_off, tq_tick;
    logic [1:0] fault_state_code;
    logic [4:0] seg1_quanta;
    logic [3:0] seg2_quanta;
    logic [2:0] sjw_quanta;
    logic [12:0] ev_req = 13'h0000;
    logic [12:0] ev;
    logic [3:0] lvl = 4'h0;
    logic [31:0] exq[$];
    int fails = 0;
    int check_count = 0;

    can_engine_model u_eng (.clk(clk), .sys_rst(sys_rst), .ev_req(ev_req), .ev(ev));
    can_mode_timing_error_regs #(.PRESC_W(8)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pe_ack_err(ev[0]), .pe_bit_err(ev[1]), .pe_stuff_err(ev[2]), .pe_form_err(ev[3]), .pe_crc_err(ev[4]),
        .pe_crc_delim_err(ev[5]), .pe_rx_inc1(ev[6]), .pe_rx_inc8(ev[7]), .pe_tx_inc8(ev[8]), .pe_rx_dec(ev[9]),
        .pe_tx_dec(ev[10]), .pe_recessive_run(ev[11]), .pe_wakeup(ev[12]), .filter_busy_in(lvl[2]),
        .tx_queue_full_in(lvl[1]), .priority_buffer_full_in(lvl[0]), .line_busy_in(lvl[3]),
        .core_on_bit(core_on_bit), .mode_config(mode_config), .mode_normal(mode_normal), .mode_sleep(mode_sleep),
        .mode_loopback(mode_loopback), .drive_recessive(drive_recessive), .bus_off(bus_off),
        .fault_state_code(fault_state_code), .seg1_quanta(seg1_quanta), .seg2_quanta(seg2_quanta),
        .sjw_quanta(sjw_quanta), .tq_tick(tq_tick));

    // 20 MHz clock
    always #25 clk = ~clk;

    // ************************************
    // helpers
    // ************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exq.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic fire(input logic [12:0] v, input int n);
        repeat (n) begin
            @(posedge clk);
            ev_req <= v;
            @(posedge clk);
            ev_req <= 13'h0000;
        end
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic tick_gap(input int e);
        int n;
        n = 0;
        repeat (600) begin
            @(posedge clk);
            if (tq_tick === 1'b1) break;
        end
        repeat (600) begin
            @(posedge clk);
            n++;
            if (tq_tick === 1'b1) break;
        end
        chk(n, e);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // read answers compared against the oldest note
    always @(posedge clk) begin
        if (reg_rvalid === 1'b1) chk(reg_rdata, exq.pop_front());
    end

    // hang guard
    initial begin
        #(50 * 12000);
        fails++;
        print_verdict();
    end

    // ************************************
    // scenarios
    // ************************************
    initial begin
        seed = 32'h0000_f5dc;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        lv = rnd();
        lvl <= lv[3:0];
        p = rnd() & 32'h0000_00ff;
        t = rnd() & 32'h0000_01ff;
        rd(8'h00, 0);
        rd(8'h04, 0);
        rd(8'h08, 0);
        rd(8'h0c, 0);
        rd(8'h10, 0);
        rd(8'h14, 0);
        rd(8'h30, 0);
        rd(8'h18, {20'h0_0000, lv[2:0], 9'h001});
        $display("test reset done");
        wr(8'h08, p);
        wr(8'h0c, t);
        wr(8'h04, 32'h0000_0003);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h08, p);
        rd(8'h0c, t);
        rd(8'h04, 32'h0000_0003);
        rd(8'h10, 0);
        chk(seg1_quanta, t[3:0] + 5'h01);
        chk(seg2_quanta, t[6:4] + 4'h1);
        chk(sjw_quanta, t[8:7] + 3'h1);
        wr(8'h00, 32'h0000_0002);
        fire(13'h0800, 1);
        chk(mode_loopback, 1'b1);
        rd(8'h18, {20'h0_0000, lv[2:0], 3'h2, lv[3], ~lv[3], 4'h2});
        tick_gap(p + 1);
        wr(8'h08, ~p & 32'h0000_00ff);
        wr(8'h0c, ~t & 32'h0000_01ff);
        wr(8'h04, 0);
        rd(8'h08, p);
        rd(8'h0c, t);
        rd(8'h04, 32'h0000_0002);
        $display("test config done");
        fire(13'h0037, 1);
        rd(8'h14, 32'h0000_001e);
        fire(13'h0010, 1);
        rd(8'h14, 32'h0000_001f);
        wr(8'h14, 32'h0000_0008);
        wr(8'h14, 0);
        rd(8'h14, 32'h0000_0017);
        $display("test flags done");
        fire(13'h0100, 3);
        fire(13'h0040, 2);
        fire(13'h0200, 1);
        fire(13'h0080, 1);
        fire(13'h0400, 1);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, 32'h0000_0917);
        fire(13'h0100, 14);
        chk(fault_state_code, 2'h3);
        rd(8'h18, {20'h0_0000, lv[2:0], 3'h7, lv[3], ~lv[3], 4'h2});
        fire(13'h0100, 15);
        chk(bus_off, 1'b0);
        fire(13'h0100, 1);
        chk(bus_off, 1'b1);
        rd(8'h10, 0);
        fire(13'h0800, 5);
        rd(8'h10, 32'h0000_0500);
        fire(13'h0800, 122);
        chk(bus_off, 1'b1);
        fire(13'h0800, 1);
        chk(fault_state_code, 2'h1);
        rd(8'h10, 0);
        $display("test counters done");
        wr(8'h00, 0);
        rd(8'h14, 0);
        chk(mode_config, 1'b1);
        wr(8'h04, 32'h0000_0001);
        wr(8'h00, 32'h0000_0002);
        fire(13'h0800, 1);
        chk(mode_sleep, 1'b1);
        rd(8'h18, {20'h0_0000, lv[2:0], 3'h2, lv[3], ~lv[3], 4'h4});
        fire(13'h1000, 1);
        rd(8'h04, 0);
        chk(mode_normal, 1'b1);
        wr(8'h00, 32'h0000_0001);
        rd(8'h08, 0);
        rd(8'h00, 0);
        chk(core_on_bit, 1'b0);
        $display("test modes done");
        print_verdict();
    end
endmodule // can_mode_timing_error_regs_tb_top
